// file: core/sli_pkg.sv
// Purpose : Constants for the front status lamp and beeper indicator.
// Assumes : One 250 MHz reference clock.
// Notes   : Error codes equal the number of red flashes per burst.
package sli_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_KHZ        = 250_000;   // Reference clock rate
  localparam int unsigned HALF_PERIOD_MS = 500;       // One flash phase
  localparam int unsigned PAUSE_MS       = 2_000;     // Gap after a burst
  localparam int unsigned HALF_CYCLES    = HALF_PERIOD_MS * CLK_KHZ;
  localparam int unsigned PAUSE_TICKS    = PAUSE_MS / HALF_PERIOD_MS;
  localparam int unsigned BEEP_BURSTS    = 5;         // Bursts that beep

  // ****************************************************************
  // Sleep states
  // ****************************************************************
  localparam logic [2:0] SLP_S0 = 3'h0;
  localparam logic [2:0] SLP_S1 = 3'h1;
  localparam logic [2:0] SLP_S3 = 3'h3;
  localparam logic [2:0] SLP_S4 = 3'h4;
  localparam logic [2:0] SLP_S5 = 3'h5;

  // ****************************************************************
  // Error codes
  // ****************************************************************
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_MIN     = 4'h2;   // Thermal shutdown
  localparam logic [3:0] ERR_MAX     = 4'ha;   // Bad add-in card
  localparam logic [3:0] ERR_SILENT  = 4'ha;   // Flashes with no beeps

  // Flash sequencer, Gray coded along idle-on-off-pause
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ON    = 2'b01,
    SEQ_OFF   = 2'b11,
    SEQ_PAUSE = 2'b10
  } sli_seq_e;
endpackage

// file: core/sli_indicator.sv
// Purpose : Drives the front status lamp (green/red) and chassis beeper.
// Assumes : Sleep state and error code come from logic on i_ref_clk.
// Notes   : All timing comes from one half-second prescaler.
//
// Summary of operation
// - S0 steady green; S4/S5 lamp dark.
// - S1 or S3 green blink 0.5 Hz.
// - Codes 2-4 flash red, equal beeps.
// - Codes 5-6 flash red, equal beeps.
// - Codes 7-9 flash red, equal beeps.
// - Code 10 flashes ten, never beeps.
// - Two-second pause, then burst repeats.
// - Beeps only for first five bursts.
`timescale 1ns/1ps
module sli_indicator #(
  parameter int unsigned HALF_CYCLES = sli_pkg::HALF_CYCLES,
  parameter int unsigned CNT_W       = 32
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_sleep_state,
  input  wire logic       i_err_load,
  input  wire logic [3:0] i_err_code,
  output logic            o_lamp_green,
  output logic            o_lamp_red,
  output logic            o_beep_en
);
  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (HALF_CYCLES < 1 || CNT_W < 2 || CNT_W > 32 || HALF_CYCLES - 1 >= (64'd1 << CNT_W)) begin : g_chk
    $error("sli_indicator: HALF_CYCLES does not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] HALF_LAST  = CNT_W'(HALF_CYCLES - 1);
  localparam logic [2:0]       PAUSE_LAST = 3'(sli_pkg::PAUSE_TICKS - 1);
  localparam logic [2:0]       BURST_MAX  = 3'(sli_pkg::BEEP_BURSTS);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CNT_W-1:0] cnt;       // Prescaler
    logic             slow_ph;   // Toggles each half second
    logic             green_ph;  // Toggles each second
    sli_pkg::sli_seq_e st;
    logic [3:0]       code;      // Latched error code
    logic [3:0]       flash;     // Flash number in burst
    logic [2:0]       pause;     // Half seconds of pause
    logic [2:0]       burst;     // Completed bursts, saturating
    logic             green;
    logic             red;
    logic             beep;
  } sli_state_s;

  sli_state_s state_r;
  sli_state_s state_nxt;
  logic       tick;
  logic       code_ok;

  // Next state
  always_comb begin
    state_nxt = state_r;
    tick      = (state_r.cnt == HALF_LAST);
    code_ok   = (i_err_code >= sli_pkg::ERR_MIN) && (i_err_code <= sli_pkg::ERR_MAX);
    state_nxt.cnt = tick ? '0 : CNT_W'(state_r.cnt + 1'b1);
    if (tick) begin
      state_nxt.slow_ph = ~state_r.slow_ph;
      if (state_r.slow_ph) begin
        state_nxt.green_ph = ~state_r.green_ph;
      end
    end
    if (i_err_load && code_ok) begin
      state_nxt.code  = i_err_code;
      state_nxt.st    = sli_pkg::SEQ_ON;
      state_nxt.flash = 4'h1;
      state_nxt.pause = 3'h0;
      state_nxt.burst = 3'h0;
      state_nxt.cnt   = '0;
    end else if (i_err_load && i_err_code == sli_pkg::ERR_NONE) begin
      state_nxt.code = sli_pkg::ERR_NONE;
      state_nxt.st   = sli_pkg::SEQ_IDLE;
    end else if (tick) begin
      unique case (state_r.st)
        sli_pkg::SEQ_IDLE: begin
          state_nxt.st = sli_pkg::SEQ_IDLE;
        end
        sli_pkg::SEQ_ON: begin
          state_nxt.st = sli_pkg::SEQ_OFF;
        end
        sli_pkg::SEQ_OFF: begin
          if (state_r.flash == state_r.code) begin
            state_nxt.st    = sli_pkg::SEQ_PAUSE;
            state_nxt.pause = 3'h0;
          end else begin
            state_nxt.st    = sli_pkg::SEQ_ON;
            state_nxt.flash = 4'(state_r.flash + 1'b1);
          end
        end
        sli_pkg::SEQ_PAUSE: begin
          if (state_r.pause == PAUSE_LAST) begin
            state_nxt.st    = sli_pkg::SEQ_ON;
            state_nxt.flash = 4'h1;
            if (state_r.burst != BURST_MAX) begin
              state_nxt.burst = 3'(state_r.burst + 1'b1);
            end
          end else begin
            state_nxt.pause = 3'(state_r.pause + 1'b1);
          end
        end
      endcase
    end
    state_nxt.green = (state_nxt.st == sli_pkg::SEQ_IDLE) &&
                      ((i_sleep_state == sli_pkg::SLP_S0) ||
                       (((i_sleep_state == sli_pkg::SLP_S1) || (i_sleep_state == sli_pkg::SLP_S3)) &&
                        state_nxt.green_ph));
    state_nxt.red  = (state_nxt.st == sli_pkg::SEQ_ON);
    // beep with each flash of the first five bursts; code 10 silent
    state_nxt.beep = state_nxt.red && (state_nxt.code != sli_pkg::ERR_SILENT) &&
                     (state_nxt.burst != BURST_MAX);
  end

  // Register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_lamp_green = state_r.green;
  assign o_lamp_red   = state_r.red;
  assign o_beep_en    = state_r.beep;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_load_err;
    i_err_load && code_ok;
  endsequence

  // Last off phase ends with no new code arriving
  sequence s_burst_end;
    tick && !i_err_load && state_r.st == sli_pkg::SEQ_OFF && state_r.flash == state_r.code;
  endsequence

  property p_s0_green;
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_r.st == sli_pkg::SEQ_IDLE && !i_err_load && i_sleep_state == sli_pkg::SLP_S0) |=> o_lamp_green;
  endproperty
  a_s0_green: assert property (p_s0_green) else $error("S0 lamp not green");

  property p_dark;
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_r.st == sli_pkg::SEQ_IDLE && !i_err_load &&
     (i_sleep_state == sli_pkg::SLP_S4 || i_sleep_state == sli_pkg::SLP_S5)) |=> !o_lamp_green && !o_lamp_red;
  endproperty
  a_dark: assert property (p_dark) else $error("S4/S5 lamp not dark");

  property p_no_sleep_beep;
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_r.st == sli_pkg::SEQ_IDLE) |-> !o_beep_en && !o_lamp_red;
  endproperty
  a_no_sleep_beep: assert property (p_no_sleep_beep) else $error("Beep or red in sleep pattern");

  // Standby blink follows the one-second phase
  property p_blink_phase;
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_r.st == sli_pkg::SEQ_IDLE && !i_err_load &&
     (i_sleep_state == sli_pkg::SLP_S1 || i_sleep_state == sli_pkg::SLP_S3)) |=> o_lamp_green == state_r.green_ph;
  endproperty
  a_blink_phase: assert property (p_blink_phase) else $error("S1/S3 blink off its phase");

  // Blink phase only moves on a prescaler wrap
  property p_green_phase;
    @(posedge i_ref_clk) disable iff (i_rst)
    $changed(state_r.green_ph) |-> $past(tick) && $past(state_r.slow_ph);
  endproperty
  a_green_phase: assert property (p_green_phase) else $error("Green phase moved off the prescaler");

  property p_load_starts;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_load_err |=> o_lamp_red && !o_lamp_green && state_r.flash == 4'h1;
  endproperty
  a_load_starts: assert property (p_load_starts) else $error("Error burst did not start");

  property p_flash_bound;
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_r.st != sli_pkg::SEQ_IDLE) |-> state_r.flash <= state_r.code && state_r.flash != 4'h0;
  endproperty
  a_flash_bound: assert property (p_flash_bound) else $error("Flash count beyond code");

  property p_beep_pairs;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_beep_en |-> o_lamp_red && state_r.code != sli_pkg::ERR_SILENT;
  endproperty
  a_beep_pairs: assert property (p_beep_pairs) else $error("Beep without red or on code 10");

  property p_beep_limit;
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_r.burst == BURST_MAX) |-> !o_beep_en;
  endproperty
  a_beep_limit: assert property (p_beep_limit) else $error("Beep after fifth burst");

  property p_pause_dark;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_burst_end ##1 (!i_err_load)[*3] |-> !o_lamp_red && !$past(o_lamp_red) && !$past(o_lamp_red, 2);
  endproperty
  a_pause_dark: assert property (p_pause_dark) else $error("Red lit during pause");

  property p_tick_period;
    @(posedge i_ref_clk) disable iff (i_rst)
    (tick && !i_err_load) |=> state_r.cnt == '0;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("Prescaler did not wrap");

  property p_code_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_err_load |=> state_r.code == $past(state_r.code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("Latched code changed");
endmodule

// file: tb/sli_fw_model.sv
// Purpose : Firmware and power-state stand-in.
// Assumes : Drives 1 ns after a rising edge.
// Notes   : Code lines are scrambled outside the load pulse.
`timescale 1ns/1ps
module sli_fw_model (
  input  wire logic       i_ref_clk,
  output logic [2:0]      o_sleep_state,
  output logic            o_err_load,
  output logic [3:0]      o_err_code
);
  // Idle values at time zero
  initial begin
    o_sleep_state = sli_pkg::SLP_S0;
    o_err_load    = 1'b0;
    o_err_code    = 4'h0;
  end

  // Sleep state is a plain level
  task automatic set_sleep(input logic [2:0] s);
    @(posedge i_ref_clk);
    #1 o_sleep_state = s;
  endtask

  task automatic send_code(input logic [3:0] c);
    @(posedge i_ref_clk);
    #1 o_err_load = 1'b1;
    o_err_code = c;
    @(posedge i_ref_clk);
    #1 o_err_load = 1'b0;
    o_err_code = ~c;  // Released lines not held
  endtask
endmodule

// file: tb/sli_indicator_bench.sv
// Purpose : Self-checking bench for the status lamp and beeper.
// Assumes : Short half period of four cycles.
// Notes   : Sleep and error cases run from one table.
`timescale 1ns/1ps
module sli_indicator_bench;
  localparam int unsigned H = 4;
  typedef struct {logic [2:0] slp; logic [3:0] code; int green_on;} sli_row_s;
  logic       i_ref_clk;
  logic       i_rst;
  logic       o_lamp_green;
  logic       o_lamp_red;
  logic       o_beep_en;
  logic       i_err_load;
  logic [2:0] i_sleep_state;
  logic [3:0] i_err_code;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         cnt;
  sli_row_s   rows[15] = '{'{0,0,16}, '{1,0,8}, '{3,0,8}, '{4,0,0}, '{5,0,0}, '{2,0,0},
    '{1,2,0}, '{3,3,0}, '{4,4,0}, '{5,5,0}, '{2,6,0}, '{1,7,0}, '{3,8,0}, '{4,9,0}, '{0,10,0}};

  sli_indicator #(.HALF_CYCLES(H)) u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sleep_state(i_sleep_state),
    .i_err_load(i_err_load), .i_err_code(i_err_code), .o_lamp_green(o_lamp_green), .o_lamp_red(o_lamp_red),
    .o_beep_en(o_beep_en));
  sli_fw_model u_fw (.i_ref_clk(i_ref_clk), .o_sleep_state(i_sleep_state), .o_err_load(i_err_load),
    .o_err_code(i_err_code));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Compares each cycle of nb bursts against the expected pattern
  task automatic run_burst(input int n, input int nb);
    int p;
    int pos;
    logic red;
    logic bp;
    p = (2 * n + 4) * H;
    for (int k = 0; k < p * nb; k++) begin
      pos = k % p;
      red = (pos < 2 * n * H) && ((pos / H) % 2 == 0);
      bp = red && (k / p < sli_pkg::BEEP_BURSTS) && (4'(n) != sli_pkg::ERR_SILENT);
      check("red", o_lamp_red, red);
      check("beep", o_beep_en, bp);
      check("green", o_lamp_green, 1'b0);
      @(posedge i_ref_clk);
      #1;
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // Cuts a hang short
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_rst = 1'b1;
    repeat (20) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    foreach (rows[i]) begin
      u_fw.send_code(4'h0);
      u_fw.set_sleep(rows[i].slp);
      if (rows[i].code == 4'h0) begin
        cnt = 0;
        repeat (4 * H) begin
          @(posedge i_ref_clk);
          #1;
          if (o_lamp_green === 1'b1) cnt++;
          check("quiet", {o_lamp_red, o_beep_en}, 2'b00);
        end
        check("green_on", cnt, rows[i].green_on);
      end else begin
        u_fw.send_code(rows[i].code);
        run_burst(rows[i].code, 6);
      end
    end
    // Restart mid-burst, then invalid codes after a clear
    u_fw.send_code(4'h3);
    repeat (10) @(posedge i_ref_clk);
    u_fw.send_code(4'h5);
    run_burst(5, 1);
    u_fw.send_code(4'h0);
    u_fw.send_code(4'h1);
    u_fw.send_code(4'hf);
    repeat (8) begin
      check("idle", {o_lamp_green, o_lamp_red, o_beep_en}, 3'b100);
      @(posedge i_ref_clk);
      #1;
    end
    // Reset in mid-burst drops the code
    u_fw.send_code(4'h7);
    repeat (5) @(posedge i_ref_clk);
    #1 i_rst = 1'b1;
    #1 check("in_reset", {o_lamp_green, o_lamp_red, o_beep_en}, 3'b000);
    @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    @(posedge i_ref_clk);
    #1 check("after_reset", {o_lamp_green, o_lamp_red, o_beep_en}, 3'b100);
    give_verdict();
  end
endmodule
